// >>> core/btsu_pkg.sv
/*
 * Shared constants of the branch, transfer and shift execution unit.
 * Assumes a decoder outside that presents one operation at a time.
 */
package btsu_pkg;
    // ==========================================================
    // Widths and reset values
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] IDX_RST = 8'h00;
    localparam logic [7:0] SP_RST = 8'hff;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] LEN_BRANCH = 16'h0002;
    localparam logic [15:0] LEN_ONE = 16'h0001;
    // ==========================================================
    // Operations
    typedef enum logic [4:0] {
        BTSU_NOP,
        BRANCH_IF_CARRY_CLEAR, BRANCH_IF_CARRY_SET,
        BRANCH_IF_EQUAL, BRANCH_IF_NOT_EQUAL,
        BRANCH_IF_MINUS, BRANCH_IF_PLUS,
        BRANCH_IF_OVERFLOW_CLEAR, BRANCH_IF_OVERFLOW_SET,
        ACC_TO_X_TRANSFER, ACC_TO_Y_TRANSFER, SP_TO_X_TRANSFER,
        X_TO_ACC_TRANSFER, Y_TO_ACC_TRANSFER, X_TO_SP_TRANSFER,
        ARITH_SHIFT_LEFT, LOGICAL_SHIFT_RIGHT,
        ROTATE_LEFT_CARRY, ROTATE_RIGHT_CARRY,
        BTSU_BIT_TEST
    } btsu_op_t;
endpackage : btsu_pkg

// >>> core/btsu_unit.sv
/*
 * Execution unit for conditional branches, register transfers and shifts.
 * Assumes op_valid pulses with a decoded operation, displacement and memory
 * byte; memory write-back is done outside from mem_wr/mem_wdata.
 */
// What this block does
// - Carry-clear branch taken on carry 0, carry-set branch on carry 1.
// - Equal branch taken on zero 1, not-equal branch on zero 0.
// - Minus branch taken on negative 1, plus branch on negative 0.
// - Overflow-clear branch on overflow 0, overflow-set branch on 1.
// - Taken branch loads program counter with the destination.
// - Untaken branch continues at the instruction after the branch.
// - Accumulator copied into X or Y, accumulator unchanged.
// - X or Y copied into the accumulator.
// - Stack pointer copied into X.
// - X copied into the stack pointer.
// - Transfers are one byte, program counter advances by one.
// - Shifts act on accumulator or memory byte, result written back there.
// - Left shift moves every bit one place toward bit 7.
// - Right shift moves bits toward bit 0, old bit 0 into carry.
// - Rotate right puts old bit 0 in carry, old carry in bit 7.
// - Rotate left puts old bit 7 in carry, old carry in bit 0.
// - Bit test copies memory bit 7 into the negative flag.
`timescale 1ns/10ps
module btsu_unit #(
    parameter int DW = btsu_pkg::DATA_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operation
    input wire logic op_valid,
    input wire btsu_pkg::btsu_op_t op_code,
    input wire logic op_use_mem,
    input wire logic [7:0] op_disp,
    input wire logic [DW-1:0] mem_rdata,
    // Flags set elsewhere
    input wire logic flag_zero_in,
    input wire logic flag_ovf_in,
    // State
    output logic [15:0] pc,
    output logic [DW-1:0] acc,
    output logic [DW-1:0] idx_x,
    output logic [DW-1:0] idx_y,
    output logic [DW-1:0] sp,
    output logic flag_carry,
    output logic flag_neg,
    // Memory write-back
    output logic mem_wr,
    output logic [DW-1:0] mem_wdata
);
    // ==========================================================
    // Checks
    // Flag and shift taps sit at bit 7, so only bytes fit
    if (DW != 8) begin : g_dw_check
        $error("btsu_unit serves 8-bit data only");
    end

    // ==========================================================
    // Reset release
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic rst_ok_n = rst_s2_reg;

    // ==========================================================
    // Decode
    logic [15:0] pc_reg, pc_next;
    logic [DW-1:0] acc_reg, acc_next, x_reg, x_next, y_reg, y_next, sp_reg, sp_next;
    logic c_reg, c_next, n_reg, n_next, wr_reg, wr_next;
    logic [DW-1:0] wd_reg, wd_next;

    wire logic is_branch = op_code inside {btsu_pkg::BRANCH_IF_CARRY_CLEAR, btsu_pkg::BRANCH_IF_CARRY_SET,
        btsu_pkg::BRANCH_IF_EQUAL, btsu_pkg::BRANCH_IF_NOT_EQUAL, btsu_pkg::BRANCH_IF_MINUS,
        btsu_pkg::BRANCH_IF_PLUS, btsu_pkg::BRANCH_IF_OVERFLOW_CLEAR, btsu_pkg::BRANCH_IF_OVERFLOW_SET};
    wire logic is_xfer = op_code inside {btsu_pkg::ACC_TO_X_TRANSFER, btsu_pkg::ACC_TO_Y_TRANSFER,
        btsu_pkg::SP_TO_X_TRANSFER, btsu_pkg::X_TO_ACC_TRANSFER, btsu_pkg::Y_TO_ACC_TRANSFER,
        btsu_pkg::X_TO_SP_TRANSFER};
    wire logic is_shift = op_code inside {btsu_pkg::ARITH_SHIFT_LEFT, btsu_pkg::LOGICAL_SHIFT_RIGHT,
        btsu_pkg::ROTATE_LEFT_CARRY, btsu_pkg::ROTATE_RIGHT_CARRY};

    wire logic cond_carry = (op_code == btsu_pkg::BRANCH_IF_CARRY_CLEAR && !c_reg)
        || (op_code == btsu_pkg::BRANCH_IF_CARRY_SET && c_reg);
    wire logic cond_zero = (op_code == btsu_pkg::BRANCH_IF_EQUAL && flag_zero_in)
        || (op_code == btsu_pkg::BRANCH_IF_NOT_EQUAL && !flag_zero_in);
    wire logic cond_neg = (op_code == btsu_pkg::BRANCH_IF_MINUS && n_reg)
        || (op_code == btsu_pkg::BRANCH_IF_PLUS && !n_reg);
    wire logic cond_ovf = (op_code == btsu_pkg::BRANCH_IF_OVERFLOW_CLEAR && !flag_ovf_in)
        || (op_code == btsu_pkg::BRANCH_IF_OVERFLOW_SET && flag_ovf_in);
    wire logic taken = cond_carry | cond_zero | cond_neg | cond_ovf;

    wire logic [15:0] pc_after = pc_reg + btsu_pkg::LEN_BRANCH;
    wire logic [15:0] pc_dest = pc_after + {{8{op_disp[7]}}, op_disp};

    wire logic [DW-1:0] sh_in = op_use_mem ? mem_rdata : acc_reg;
    logic [DW-1:0] sh_out;
    logic sh_c;
    always_comb begin
        sh_out = sh_in;
        sh_c = c_reg;
        case (op_code)
            btsu_pkg::ARITH_SHIFT_LEFT: begin
                sh_out = {sh_in[DW-2:0], 1'b0};
                sh_c = sh_in[DW-1];
            end
            btsu_pkg::LOGICAL_SHIFT_RIGHT: begin
                sh_out = {1'b0, sh_in[DW-1:1]};
                sh_c = sh_in[0];
            end
            btsu_pkg::ROTATE_LEFT_CARRY: begin
                sh_out = {sh_in[DW-2:0], c_reg};
                sh_c = sh_in[DW-1];
            end
            btsu_pkg::ROTATE_RIGHT_CARRY: begin
                sh_out = {c_reg, sh_in[DW-1:1]};
                sh_c = sh_in[0];
            end
            default: begin
                sh_out = sh_in;
                sh_c = c_reg;
            end
        endcase
    end

    always_comb begin
        pc_next = pc_reg;
        acc_next = acc_reg;
        x_next = x_reg;
        y_next = y_reg;
        sp_next = sp_reg;
        c_next = c_reg;
        n_next = n_reg;
        wr_next = 1'b0;
        wd_next = wd_reg;
        if (op_valid) begin
            case (op_code)
                btsu_pkg::ACC_TO_X_TRANSFER: x_next = acc_reg;
                btsu_pkg::ACC_TO_Y_TRANSFER: y_next = acc_reg;
                btsu_pkg::SP_TO_X_TRANSFER: x_next = sp_reg;
                btsu_pkg::X_TO_ACC_TRANSFER: acc_next = x_reg;
                btsu_pkg::Y_TO_ACC_TRANSFER: acc_next = y_reg;
                btsu_pkg::X_TO_SP_TRANSFER: sp_next = x_reg;
                btsu_pkg::BTSU_BIT_TEST: n_next = mem_rdata[DW-1];
                default: begin
                end
            endcase
            if (is_branch) begin
                pc_next = taken ? pc_dest : pc_after;
            end
            if (is_xfer) begin
                pc_next = pc_reg + btsu_pkg::LEN_ONE;
            end
            if (is_shift) begin
                c_next = sh_c;
                n_next = sh_out[DW-1];
                if (op_use_mem) begin
                    wr_next = 1'b1;
                    wd_next = sh_out;
                end else begin
                    acc_next = sh_out;
                end
            end
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge clk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
            pc_reg <= btsu_pkg::PC_RST;
            acc_reg <= btsu_pkg::ACC_RST;
            x_reg <= btsu_pkg::IDX_RST;
            y_reg <= btsu_pkg::IDX_RST;
            sp_reg <= btsu_pkg::SP_RST;
            c_reg <= 1'b0;
            n_reg <= 1'b0;
            wr_reg <= 1'b0;
            wd_reg <= '0;
        end else begin
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            x_reg <= x_next;
            y_reg <= y_next;
            sp_reg <= sp_next;
            c_reg <= c_next;
            n_reg <= n_next;
            wr_reg <= wr_next;
            wd_reg <= wd_next;
        end
    end

    assign pc = pc_reg;
    assign acc = acc_reg;
    assign idx_x = x_reg;
    assign idx_y = y_reg;
    assign sp = sp_reg;
    assign flag_carry = c_reg;
    assign flag_neg = n_reg;
    assign mem_wr = wr_reg;
    assign mem_wdata = wd_reg;

    // ==========================================================
    // Checks on behaviour
    wire logic fire = op_valid && rst_ok_n;

    a_carry_branch_taken: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BRANCH_IF_CARRY_SET && c_reg |=> pc_reg == $past(pc_dest))
        else $error("carry-set branch not taken");
    a_zero_branch_skip: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BRANCH_IF_EQUAL && !flag_zero_in |=> pc_reg == $past(pc_reg) + 16'h0002)
        else $error("equal branch taken on zero 0");
    a_neg_branch_plus: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BRANCH_IF_PLUS && !n_reg |=> pc_reg == $past(pc_dest))
        else $error("plus branch not taken");
    a_ovf_branch_clear: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BRANCH_IF_OVERFLOW_CLEAR && flag_ovf_in |=> pc_reg == $past(pc_after))
        else $error("overflow-clear branch taken on overflow 1");
    a_xfer_pc_step: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && is_xfer |=> pc_reg == $past(pc_reg) + 16'h0001)
        else $error("transfer did not step by one");
    a_acc_to_x: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::ACC_TO_X_TRANSFER |=> x_reg == $past(acc_reg) && acc_reg == $past(acc_reg))
        else $error("accumulator to X wrong");
    a_x_to_sp: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::X_TO_SP_TRANSFER |=> sp_reg == $past(x_reg))
        else $error("X to stack pointer wrong");
    a_rotate_right_mem: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::ROTATE_RIGHT_CARRY && op_use_mem
        |=> mem_wr && mem_wdata == {$past(c_reg), $past(mem_rdata[7:1])} && c_reg == $past(mem_rdata[0]))
        else $error("rotate right to memory wrong");
    a_bit_test_neg: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BTSU_BIT_TEST |=> n_reg == $past(mem_rdata[7]))
        else $error("bit test negative wrong");
    a_carry_clear_skip: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::BRANCH_IF_CARRY_CLEAR && c_reg |=> pc_reg == $past(pc_reg) + 16'h0002)
        else $error("carry-clear branch taken on carry 1");
    // Destination recomputed from sampled inputs, not from pc_dest
    a_branch_dest: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && is_branch && taken
        |=> pc_reg == $past(pc_reg) + 16'h0002 + {{8{$past(op_disp[7])}}, $past(op_disp)})
        else $error("branch destination wrong");
    a_branch_fall: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && is_branch && !taken |=> pc_reg == $past(pc_reg) + 16'h0002)
        else $error("untaken branch did not fall through");
    a_y_to_acc: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::Y_TO_ACC_TRANSFER |=> acc_reg == $past(y_reg))
        else $error("Y to accumulator wrong");
    a_sp_to_x: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::SP_TO_X_TRANSFER |=> x_reg == $past(sp_reg))
        else $error("stack pointer to X wrong");
    a_left_shift_acc: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::ARITH_SHIFT_LEFT && !op_use_mem
        |=> acc_reg == {$past(acc_reg[6:0]), 1'b0} && c_reg == $past(acc_reg[7]))
        else $error("left shift of accumulator wrong");
    a_right_shift_acc: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::LOGICAL_SHIFT_RIGHT && !op_use_mem
        |=> acc_reg == {1'b0, $past(acc_reg[7:1])} && c_reg == $past(acc_reg[0]))
        else $error("right shift of accumulator wrong");
    a_right_shift_mem: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::LOGICAL_SHIFT_RIGHT && op_use_mem
        |=> mem_wr && mem_wdata == {1'b0, $past(mem_rdata[7:1])})
        else $error("right shift of memory byte wrong");
    a_rotate_left_acc: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && op_code == btsu_pkg::ROTATE_LEFT_CARRY && !op_use_mem
        |=> acc_reg == {$past(acc_reg[6:0]), $past(c_reg)} && c_reg == $past(acc_reg[7]))
        else $error("rotate left of accumulator wrong");
    a_shift_mem_place: assert property (@(posedge clk) disable iff (!rst_ok_n)
        fire && is_shift && op_use_mem |=> mem_wr && acc_reg == $past(acc_reg))
        else $error("memory shift touched the accumulator");

    c_branch_taken: cover property (@(posedge clk) disable iff (!rst_ok_n) fire && is_branch && taken);
    c_branch_skip: cover property (@(posedge clk) disable iff (!rst_ok_n) fire && is_branch && !taken);
    c_shift_mem: cover property (@(posedge clk) disable iff (!rst_ok_n) fire && is_shift && op_use_mem);
    c_xfer_done: cover property (@(posedge clk) disable iff (!rst_ok_n) fire && is_xfer);
    c_bit_test: cover property (@(posedge clk) disable iff (!rst_ok_n) fire && op_code == btsu_pkg::BTSU_BIT_TEST);
endmodule : btsu_unit

// >>> tb/test_btsu_unit.sv
/*
 * Self-checking bench of the branch, transfer and shift unit.
 * Assumes the registered one-cycle answer and reset values of btsu_pkg.
 */
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            err_total++; \
            $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module test_btsu_unit;
    // ==========================================================
    // Signals and model state
    typedef struct packed {logic [15:0] pc; logic [7:0] a, x, y, s; logic c, n, w; logic [7:0] wd;} btsu_exp_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    btsu_pkg::btsu_op_t op_code = btsu_pkg::BTSU_NOP;
    logic op_use_mem = 1'b0;
    logic [7:0] op_disp = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic flag_zero_in = 1'b0;
    logic flag_ovf_in = 1'b0;
    logic [15:0] pc;
    logic [7:0] acc, idx_x, idx_y, sp, mem_wdata;
    logic flag_carry, flag_neg, mem_wr;
    btsu_exp_t m, ex;
    btsu_exp_t exp_q[$];
    logic [31:0] seed = 32'h0000001b;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    int i;
    logic chk_due = 1'b0;
    btsu_unit u_btsu_unit (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_use_mem(op_use_mem), .op_disp(op_disp), .mem_rdata(mem_rdata), .flag_zero_in(flag_zero_in),
        .flag_ovf_in(flag_ovf_in), .pc(pc), .acc(acc), .idx_x(idx_x), .idx_y(idx_y), .sp(sp),
        .flag_carry(flag_carry), .flag_neg(flag_neg), .mem_wr(mem_wr), .mem_wdata(mem_wdata));
    always #5 clk = ~clk;
    // ==========================================================
    // Helpers
    function automatic logic [7:0] rb();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rb
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic idle(input int n);
        op_valid = 1'b0;
        chk_due = 1'b0;
        op_code = btsu_pkg::btsu_op_t'(rb() % 20);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : idle
    // Refused cycles: op_valid low with random fields, state must not move
    task automatic refuse_op(input int n);
        repeat (n) begin
            op_valid = 1'b0;
            chk_due = 1'b1;
            op_code = btsu_pkg::btsu_op_t'(rb() % 20);
            op_use_mem = 1'(rb());
            mem_rdata = rb();
            m.w = 1'b0;
            m.wd = 8'h00;
            exp_q.push_back(m);
            @(posedge clk);
            #1;
        end
    endtask : refuse_op
    // Reset drops the model too; one idle cycle first so the last answer is checked
    task automatic do_reset();
        idle(1);
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        m = {btsu_pkg::PC_RST, btsu_pkg::ACC_RST, btsu_pkg::IDX_RST, btsu_pkg::IDX_RST, btsu_pkg::SP_RST, 11'h000};
        rst_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic do_op(input btsu_pkg::btsu_op_t op, input logic um, input logic [7:0] d, input logic [7:0] md);
        logic [7:0] src, r, t;
        logic [3:0] fl;
        logic co, tk;
        int k;
        t = rb();
        op_valid = 1'b1;
        chk_due = 1'b1;
        op_code = op;
        op_use_mem = um;
        op_disp = d;
        mem_rdata = md;
        flag_zero_in = t[0];
        flag_ovf_in = t[1];
        k = int'(op);
        fl = {t[1], m.n, t[0], m.c};
        src = um ? md : m.a;
        r = src;
        co = m.c;
        m.w = 1'b0;
        m.wd = 8'h00;
        if (k >= 1 && k <= 8) begin
            // Bit k-1 of 8'h96 is the flag level that takes branch k
            tk = (fl[(k - 1) / 2] == 1'(8'h96 >> (k - 1)));
            m.pc = m.pc + 16'h0002 + (tk ? {{8{d[7]}}, d} : 16'h0000);
        end
        case (op)
            btsu_pkg::ACC_TO_X_TRANSFER: m.x = m.a;
            btsu_pkg::ACC_TO_Y_TRANSFER: m.y = m.a;
            btsu_pkg::SP_TO_X_TRANSFER: m.x = m.s;
            btsu_pkg::X_TO_ACC_TRANSFER: m.a = m.x;
            btsu_pkg::Y_TO_ACC_TRANSFER: m.a = m.y;
            btsu_pkg::X_TO_SP_TRANSFER: m.s = m.x;
            btsu_pkg::ARITH_SHIFT_LEFT: {co, r} = {src, 1'b0};
            btsu_pkg::LOGICAL_SHIFT_RIGHT: {r, co} = {1'b0, src};
            btsu_pkg::ROTATE_LEFT_CARRY: {co, r} = {src, m.c};
            btsu_pkg::ROTATE_RIGHT_CARRY: {r, co} = {m.c, src};
            btsu_pkg::BTSU_BIT_TEST: m.n = md[7];
            default: ;
        endcase
        if (k >= 9 && k <= 14) m.pc = m.pc + 16'h0001;
        if (k >= 15 && k <= 18) begin
            m.c = co;
            m.n = r[7];
            if (um) {m.w, m.wd} = {1'b1, r};
            else m.a = r;
        end
        exp_q.push_back(m);
        @(posedge clk);
        #1;
    endtask : do_op
    // Shift random bits into the accumulator through carry
    task automatic load_acc();
        repeat (8) begin
            do_op(btsu_pkg::LOGICAL_SHIFT_RIGHT, 1'b1, rb(), rb());
            do_op(btsu_pkg::ROTATE_LEFT_CARRY, 1'b0, rb(), rb());
        end
    endtask : load_acc
    // ==========================================================
    // Watcher of answers
    always @(posedge clk) begin
        if (chk_due === 1'b1) begin
            #2;
            ex = exp_q.pop_front();
            `CHK(pc, ex.pc)
            `CHK({acc, idx_x, idx_y, sp}, {ex.a, ex.x, ex.y, ex.s})
            `CHK({flag_carry, flag_neg}, {ex.c, ex.n})
            `CHK({mem_wr, mem_wr ? mem_wdata : 8'h00}, {ex.w, ex.wd})
        end
    end
    // Hang guard, far above the few hundred cycles used
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        do_reset();
        load_acc();
        for (i = 0; i < 20; i++) do_op(btsu_pkg::btsu_op_t'(i), 1'(rb()), rb(), rb());
        for (i = 0; i < 300; i++) begin
            if (i % 50 == 0) load_acc();
            if (i % 50 == 25) refuse_op(3);
            do_op(btsu_pkg::btsu_op_t'(rb() % 20), 1'(rb()), rb(), rb());
        end
        idle(3);
        do_op(btsu_pkg::BRANCH_IF_CARRY_SET, 1'b0, 8'h80, 8'h00);
        do_op(btsu_pkg::BRANCH_IF_CARRY_CLEAR, 1'b0, 8'h80, 8'h00);
        do_op(btsu_pkg::BRANCH_IF_PLUS, 1'b0, 8'h7f, 8'h00);
        do_op(btsu_pkg::BRANCH_IF_MINUS, 1'b0, 8'h7f, 8'h00);
        do_reset();
        do_op(btsu_pkg::BTSU_NOP, 1'b0, rb(), rb());
        do_op(btsu_pkg::SP_TO_X_TRANSFER, 1'b0, rb(), rb());
        idle(3);
        give_verdict();
    end
endmodule : test_btsu_unit
